// ===== rfs_demod_model.sv
/* Demodulator stand-in: one-cycle event pulses on ref_clk.
   Assumes the bench calls pulse from its main process. */
module rfs_demod_model (
    input wire logic ref_clk,
    output rfs_pkg::rfs_rx_ev_t rx_ev
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_ev = '0;
    // Length bus idles at all ones after each pulse (zero before the first), never a stale frame length
    task pulse(input rfs_pkg::rfs_rx_ev_t e);
        @(posedge ref_clk);
        rx_ev <= e;
        @(posedge ref_clk);
        rx_ev <= '{length: 11'h7FF, default: 1'b0};
    endtask : pulse
endmodule : rfs_demod_model

// ===== rfs_pkg.sv
/*
 * Package of the radio frame sequencer: register map, field layout,
 * reset values, commands and timing figures.
 * Assumes a Wishbone classic slave with 32-bit data, byte addressed.
 */
package rfs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] RFS_CMD_OFF = 8'h00;
    localparam logic [7:0] RFS_STATE_OFF = 8'h04;
    localparam logic [7:0] RFS_IRQ_OFF = 8'h08;
    localparam logic [7:0] RFS_CTRL_OFF = 8'h0C;
    localparam logic [7:0] RFS_EDC_OFF = 8'h10;
    localparam logic [7:0] RFS_EDV_OFF = 8'h14;
    localparam logic [7:0] RFS_EDT_OFF = 8'h18;
    localparam logic [7:0] RFS_RXFLL_OFF = 8'h1C;
    localparam logic [7:0] RFS_RXFLH_OFF = 8'h20;
    localparam logic [7:0] RFS_TXFLL_OFF = 8'h24;
    localparam logic [7:0] RFS_TXFLH_OFF = 8'h28;
    localparam logic [7:0] RFS_ACKTL_OFF = 8'h2C;
    localparam logic [7:0] RFS_ACKTH_OFF = 8'h30;
    localparam logic [7:0] RFS_RXBASE_OFF = 8'h34;
    localparam logic [7:0] RFS_TXBASE_OFF = 8'h38;

    ////////////////////////////////////////////////////////////////////////////
    // Commands
    localparam logic [2:0] RFS_CMD_OFF_C = 3'h0;
    localparam logic [2:0] RFS_CMD_TRANSMIT_PREPARE_STATE = 3'h1;
    localparam logic [2:0] RFS_CMD_RX = 3'h2;
    localparam logic [2:0] RFS_CMD_TX = 3'h3;

    // Control bit positions
    localparam int RFS_CTRL_CCATX = 0;
    localparam int RFS_CTRL_AACK = 1;
    localparam int RFS_CTRL_TX2RX = 2;
    localparam int RFS_CTRL_BBEN = 3;
    localparam int RFS_CTRL_FILT = 4;
    localparam int RFS_CTRL_BUSY = 5;
    localparam logic [7:0] RFS_CTRL_RST = 8'h08;
    localparam logic [1:0] RFS_EDM_SINGLE = 2'h1;
    localparam logic [7:0] RFS_BASE_RST = 8'h00;

    // Irq bit positions
    localparam int RFS_IRQ_RXFS = 0;
    localparam int RFS_IRQ_RXAM = 1;
    localparam int RFS_IRQ_RXFE = 2;
    localparam int RFS_IRQ_TXFE = 3;
    localparam int RFS_IRQ_EDC = 4;
    localparam int RFS_IRQ_RDY = 5;
    localparam int RFS_IRQ_W = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Timing, 200 MHz clock
    localparam int RFS_CLK_MHZ = 200;
    localparam int RFS_SETTLE_NS = 100;
    localparam int RFS_SETTLE_CYC = (RFS_SETTLE_NS * RFS_CLK_MHZ + 999) / 1000;
    localparam int RFS_ED_CYC_DEF = 16;
    localparam int RFS_RAMP_CYC = 8;
    localparam int RFS_ACK_LEN = 5;

    typedef enum logic [3:0] {
        RFS_S_OFF = 4'b0001,
        RFS_S_PREP = 4'b0010,
        RFS_S_RX = 4'b0100,
        RFS_S_TX = 4'b1000
    } rfs_state_t;

    // Demodulator events towards the sequencer
    typedef struct packed {
        logic preamble;
        logic header_ok;
        logic addr_match;
        logic frame_end;
        logic fcs_ok;
        logic [10:0] length;
    } rfs_rx_ev_t;

    // Radio controls from the sequencer
    typedef struct packed {
        logic agc_freeze;
        logic synth_on;
        logic pa_on;
        logic bb_active;
        logic tx_is_ack;
    } rfs_radio_t;

endpackage : rfs_pkg

// ===== rfs_seq.sv
/*
 * Radio frame sequencer: state control for off, transmit-prepare,
 * receive and transmit, energy measurement, assess-then-transmit and
 * automatic acknowledgement, with a Wishbone classic register slave.
 * Assumes demodulator events arrive as one-cycle pulses on ref_clk,
 * and that the energy value is presented by the analog path.
 */
// Functional notes
// RL1: Receive command enters receive state
// RL2: Preamble freezes gain control for frame
// RL3: Valid header raises frame start irq
// RL4: Enabled filter match raises address irq
// RL5: Good checksum irq, go transmit-prepare
// RL6: Bad frame stays receive, releases gain
// RL7: Frame length shown in two registers
// RL8: Frame start also starts energy measure
// RL9: Prepare from off tunes then ready irq
// RL10: Mode one starts single energy measure
// RL11: Auto transmit needs enable and threshold
// RL12: Idle channel goes transmit, ready irq
// RL13: Energy done updates channel busy bit
// RL14: Busy channel stays in receive
// RL15: Transmit re-enables baseband, ramps, sends
// RL16: Auto procedure always ends with tx irq
// RL17: Length includes checksum, device appends it
// RL18: Host loads frame before it is needed
// RL19: Host disables other automatics meanwhile
// RL20: Host does backoff, re-enables baseband
// RL21: Ack due starts delay timer, then sends
// RL22: Ack end raises tx irq, to prepare
// RL23: Transmit command only in transmit-prepare
module rfs_seq #(
    parameter int ED_CYC = rfs_pkg::RFS_ED_CYC_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire rfs_pkg::rfs_rx_ev_t rx_ev,
    input wire logic [7:0] energy_in,
    input wire logic tx_done,
    output rfs_pkg::rfs_radio_t radio_o,
    output logic [10:0] tx_len_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic acc;
    logic wr;
    logic hit;
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    always_comb begin
        unique case (wb_adr_i)
            rfs_pkg::RFS_CMD_OFF, rfs_pkg::RFS_STATE_OFF, rfs_pkg::RFS_IRQ_OFF,
            rfs_pkg::RFS_CTRL_OFF, rfs_pkg::RFS_EDC_OFF, rfs_pkg::RFS_EDV_OFF,
            rfs_pkg::RFS_EDT_OFF, rfs_pkg::RFS_RXFLL_OFF, rfs_pkg::RFS_RXFLH_OFF,
            rfs_pkg::RFS_TXFLL_OFF, rfs_pkg::RFS_TXFLH_OFF, rfs_pkg::RFS_ACKTL_OFF,
            rfs_pkg::RFS_ACKTH_OFF, rfs_pkg::RFS_RXBASE_OFF, rfs_pkg::RFS_TXBASE_OFF: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign wr = acc && hit && wb_we_i && wb_sel_i[0];

    function automatic logic wr_at(input logic [7:0] off);
        wr_at = wr && (wb_adr_i == off);
    endfunction : wr_at

    ////////////////////////////////////////////////////////////////////////////
    // State
    rfs_pkg::rfs_state_t state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] ackt_ff, nxt_ackt;
    logic [15:0] ackd_ff, nxt_ackd;
    logic ack_pend_ff, nxt_ack_pend;
    logic ed_run_ff, nxt_ed_run;
    logic ed_auto_ff, nxt_ed_auto;
    logic cca_ff, nxt_cca;
    logic tuning_ff, nxt_tuning;
    logic agc_ff, nxt_agc;
    logic tx_ack_ff, nxt_tx_ack;
    logic [rfs_pkg::RFS_IRQ_W-1:0] irq_ff, nxt_irq;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] edt_ff, nxt_edt;
    logic edt_set_ff, nxt_edt_set;
    logic [7:0] edv_ff, nxt_edv;
    logic [10:0] rxfl_ff, nxt_rxfl;
    logic [10:0] txfl_ff, nxt_txfl;
    logic [7:0] rxbase_ff, nxt_rxbase;
    logic [7:0] txbase_ff, nxt_txbase;
    logic [7:0] energy_s1_ff, energy_s2_ff;
    logic ed_done;
    logic [rfs_pkg::RFS_IRQ_W-1:0] ev;
    logic [2:0] cmd;

    assign cmd = wb_dat_i[2:0];
    assign ed_done = ed_run_ff && (cnt_ff == 16'h0000);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : 16'h0000;
        nxt_ackt = (ackt_ff != 16'h0000) ? ackt_ff - 16'h0001 : 16'h0000;
        nxt_ackd = ackd_ff;
        nxt_ack_pend = ack_pend_ff;
        nxt_ed_run = ed_run_ff;
        nxt_ed_auto = ed_auto_ff;
        nxt_cca = cca_ff;
        nxt_tuning = tuning_ff;
        nxt_agc = agc_ff;
        nxt_tx_ack = tx_ack_ff;
        nxt_ctrl = ctrl_ff;
        nxt_edt = edt_ff;
        nxt_edt_set = edt_set_ff;
        nxt_edv = edv_ff;
        nxt_rxfl = rxfl_ff;
        nxt_txfl = txfl_ff;
        nxt_rxbase = rxbase_ff;
        nxt_txbase = txbase_ff;
        ev = '0;
        // Configuration writes
        if (wr_at(rfs_pkg::RFS_CTRL_OFF)) begin
            nxt_ctrl[4:0] = wb_dat_i[4:0];
        end
        if (wr_at(rfs_pkg::RFS_EDT_OFF)) begin
            nxt_edt = wb_dat_i[7:0];
            nxt_edt_set = 1'b1;
        end
        if (wr_at(rfs_pkg::RFS_TXFLL_OFF)) begin
            nxt_txfl[7:0] = wb_dat_i[7:0];
        end
        if (wr_at(rfs_pkg::RFS_TXFLH_OFF)) begin
            nxt_txfl[10:8] = wb_dat_i[2:0];
        end
        if (wr_at(rfs_pkg::RFS_ACKTL_OFF)) begin
            nxt_ackd[7:0] = wb_dat_i[7:0];
        end
        if (wr_at(rfs_pkg::RFS_ACKTH_OFF)) begin
            nxt_ackd[15:8] = wb_dat_i[7:0];
        end
        if (wr_at(rfs_pkg::RFS_RXBASE_OFF)) begin
            nxt_rxbase = wb_dat_i[7:0];
        end
        if (wr_at(rfs_pkg::RFS_TXBASE_OFF)) begin
            nxt_txbase = wb_dat_i[7:0];
        end
        unique case (state_ff)
            rfs_pkg::RFS_S_OFF: begin
                // RL9: tune, then ready
                if (wr_at(rfs_pkg::RFS_CMD_OFF) && cmd == rfs_pkg::RFS_CMD_TRANSMIT_PREPARE_STATE) begin
                    nxt_tuning = 1'b1;
                    nxt_cnt = 16'(rfs_pkg::RFS_SETTLE_CYC);
                end
                if (tuning_ff && cnt_ff == 16'h0000) begin
                    nxt_tuning = 1'b0;
                    nxt_state = rfs_pkg::RFS_S_PREP;
                    ev[rfs_pkg::RFS_IRQ_RDY] = 1'b1;
                end
            end
            rfs_pkg::RFS_S_PREP: begin
                if (wr_at(rfs_pkg::RFS_CMD_OFF)) begin
                    unique case (cmd)
                        // RL1: enter receive
                        rfs_pkg::RFS_CMD_RX: nxt_state = rfs_pkg::RFS_S_RX;
                        // RL23: transmit only from here
                        rfs_pkg::RFS_CMD_TX: begin
                            nxt_state = rfs_pkg::RFS_S_TX;
                            nxt_cnt = 16'(rfs_pkg::RFS_RAMP_CYC) + {5'h00, txfl_ff} + 16'(rfs_pkg::RFS_RAMP_CYC);
                            nxt_tx_ack = 1'b0;
                        end
                        rfs_pkg::RFS_CMD_OFF_C: nxt_state = rfs_pkg::RFS_S_OFF;
                        default: ;
                    endcase
                end
                // RL21: ack sent when delay expires
                if (ack_pend_ff && ackt_ff == 16'h0000) begin
                    nxt_ack_pend = 1'b0;
                    nxt_state = rfs_pkg::RFS_S_TX;
                    nxt_tx_ack = 1'b1;
                    nxt_cnt = 16'(rfs_pkg::RFS_RAMP_CYC + rfs_pkg::RFS_ACK_LEN + rfs_pkg::RFS_RAMP_CYC);
                end
            end
            rfs_pkg::RFS_S_RX: begin
                if (wr_at(rfs_pkg::RFS_CMD_OFF) && cmd == rfs_pkg::RFS_CMD_TRANSMIT_PREPARE_STATE) begin
                    nxt_state = rfs_pkg::RFS_S_PREP;
                    nxt_agc = 1'b0;
                    nxt_ed_run = 1'b0;
                    ev[rfs_pkg::RFS_IRQ_RDY] = 1'b1;
                end
                // RL10: single measurement start
                if (wr_at(rfs_pkg::RFS_EDC_OFF) && wb_dat_i[1:0] == rfs_pkg::RFS_EDM_SINGLE) begin
                    nxt_ed_run = 1'b1;
                    nxt_ed_auto = 1'b0;
                    nxt_cnt = 16'(ED_CYC);
                    // RL11: needs enable and threshold
                    nxt_cca = ctrl_ff[rfs_pkg::RFS_CTRL_CCATX] && edt_set_ff;
                end
                if (ctrl_ff[rfs_pkg::RFS_CTRL_BBEN]) begin
                    // RL2: freeze on preamble
                    if (rx_ev.preamble) begin
                        nxt_agc = 1'b1;
                    end
                    // RL3: frame start
                    if (rx_ev.header_ok) begin
                        ev[rfs_pkg::RFS_IRQ_RXFS] = 1'b1;
                        // RL8: energy measure with frame start
                        nxt_ed_run = 1'b1;
                        nxt_ed_auto = 1'b1;
                        nxt_cnt = 16'(ED_CYC);
                    end
                    // RL4: address match
                    if (rx_ev.addr_match && ctrl_ff[rfs_pkg::RFS_CTRL_FILT]) begin
                        ev[rfs_pkg::RFS_IRQ_RXAM] = 1'b1;
                    end
                    if (rx_ev.frame_end) begin
                        nxt_agc = 1'b0;
                        if (rx_ev.fcs_ok) begin
                            // RL5: good frame ends receive
                            ev[rfs_pkg::RFS_IRQ_RXFE] = 1'b1;
                            nxt_state = rfs_pkg::RFS_S_PREP;
                            // RL7: length shown
                            nxt_rxfl = rx_ev.length;
                            // RL21: ack timer start
                            if (ctrl_ff[rfs_pkg::RFS_CTRL_AACK] && ctrl_ff[rfs_pkg::RFS_CTRL_FILT]
                                && rx_ev.addr_match) begin
                                nxt_ack_pend = 1'b1;
                                // Delay runs from frame end
                                nxt_ackt = ackd_ff;
                            end
                        end
                        // RL6: bad frame stays, gain released
                    end
                end
                if (ed_done) begin
                    nxt_ed_run = 1'b0;
                    nxt_edv = energy_s2_ff;
                    if (!ed_auto_ff) begin
                        ev[rfs_pkg::RFS_IRQ_EDC] = 1'b1;
                        // RL13: busy bit from comparison
                        nxt_ctrl[rfs_pkg::RFS_CTRL_BUSY] = (energy_s2_ff > edt_ff);
                    end
                    if (cca_ff && !ed_auto_ff) begin
                        nxt_cca = 1'b0;
                        if (energy_s2_ff < edt_ff) begin
                            // RL12: idle, straight from receive to transmit
                            ev[rfs_pkg::RFS_IRQ_RDY] = 1'b1;
                            nxt_state = rfs_pkg::RFS_S_TX;
                            nxt_tx_ack = 1'b0;
                            // RL15: baseband back on
                            nxt_ctrl[rfs_pkg::RFS_CTRL_BBEN] = 1'b1;
                            nxt_cnt = 16'(rfs_pkg::RFS_RAMP_CYC) + {5'h00, txfl_ff} + 16'(rfs_pkg::RFS_RAMP_CYC);
                        end else begin
                            // RL14: busy stays receive
                            // RL16: end of procedure irq
                            ev[rfs_pkg::RFS_IRQ_TXFE] = 1'b1;
                        end
                    end
                end
            end
            rfs_pkg::RFS_S_TX: begin
                // RL16: ramp-down done, irq and prepare
                // RL22: ack end the same way
                if (cnt_ff == 16'h0000 || tx_done) begin
                    ev[rfs_pkg::RFS_IRQ_TXFE] = 1'b1;
                    nxt_state = rfs_pkg::RFS_S_PREP;
                    nxt_tx_ack = 1'b0;
                end
            end
            default: nxt_state = rfs_pkg::RFS_S_OFF;
        endcase
        // Any state may go off, except mid-transmit
        if (wr_at(rfs_pkg::RFS_CMD_OFF) && cmd == rfs_pkg::RFS_CMD_OFF_C
            && state_ff != rfs_pkg::RFS_S_TX) begin
            nxt_state = rfs_pkg::RFS_S_OFF;
            nxt_agc = 1'b0;
            nxt_ed_run = 1'b0;
            nxt_ack_pend = 1'b0;
            nxt_tuning = 1'b0;
        end
        // Set beats write-one-to-clear
        nxt_irq = irq_ff;
        if (wr_at(rfs_pkg::RFS_IRQ_OFF)) begin
            nxt_irq = irq_ff & ~wb_dat_i[rfs_pkg::RFS_IRQ_W-1:0];
        end
        nxt_irq = nxt_irq | ev;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= rfs_pkg::RFS_S_OFF;
            cnt_ff <= 16'h0000;
            ackt_ff <= 16'h0000;
            ackd_ff <= 16'h0000;
            ack_pend_ff <= 1'b0;
            ed_run_ff <= 1'b0;
            ed_auto_ff <= 1'b0;
            cca_ff <= 1'b0;
            tuning_ff <= 1'b0;
            agc_ff <= 1'b0;
            tx_ack_ff <= 1'b0;
            irq_ff <= '0;
            ctrl_ff <= rfs_pkg::RFS_CTRL_RST;
            edt_ff <= 8'h00;
            edt_set_ff <= 1'b0;
            edv_ff <= 8'h00;
            rxfl_ff <= 11'h000;
            txfl_ff <= 11'h000;
            rxbase_ff <= rfs_pkg::RFS_BASE_RST;
            txbase_ff <= rfs_pkg::RFS_BASE_RST;
            energy_s1_ff <= 8'h00;
            energy_s2_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ackt_ff <= nxt_ackt;
            ackd_ff <= nxt_ackd;
            ack_pend_ff <= nxt_ack_pend;
            ed_run_ff <= nxt_ed_run;
            ed_auto_ff <= nxt_ed_auto;
            cca_ff <= nxt_cca;
            tuning_ff <= nxt_tuning;
            agc_ff <= nxt_agc;
            tx_ack_ff <= nxt_tx_ack;
            irq_ff <= nxt_irq;
            ctrl_ff <= nxt_ctrl;
            edt_ff <= nxt_edt;
            edt_set_ff <= nxt_edt_set;
            edv_ff <= nxt_edv;
            rxfl_ff <= nxt_rxfl;
            txfl_ff <= nxt_txfl;
            rxbase_ff <= nxt_rxbase;
            txbase_ff <= nxt_txbase;
            // Analog energy value is asynchronous
            energy_s1_ff <= energy_in;
            energy_s2_ff <= energy_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer, one wait state
    logic [31:0] nxt_dat;
    logic nxt_ack, nxt_err;
    always_comb begin
        nxt_dat = 32'h0000_0000;
        unique case (wb_adr_i)
            rfs_pkg::RFS_STATE_OFF: nxt_dat[3:0] = state_ff;
            rfs_pkg::RFS_IRQ_OFF: nxt_dat[rfs_pkg::RFS_IRQ_W-1:0] = irq_ff;
            rfs_pkg::RFS_CTRL_OFF: nxt_dat[7:0] = ctrl_ff;
            rfs_pkg::RFS_EDC_OFF: nxt_dat[0] = ed_run_ff;
            rfs_pkg::RFS_EDV_OFF: nxt_dat[7:0] = edv_ff;
            rfs_pkg::RFS_EDT_OFF: nxt_dat[7:0] = edt_ff;
            rfs_pkg::RFS_RXFLL_OFF: nxt_dat[7:0] = rxfl_ff[7:0];
            rfs_pkg::RFS_RXFLH_OFF: nxt_dat[2:0] = rxfl_ff[10:8];
            rfs_pkg::RFS_TXFLL_OFF: nxt_dat[7:0] = txfl_ff[7:0];
            rfs_pkg::RFS_TXFLH_OFF: nxt_dat[2:0] = txfl_ff[10:8];
            rfs_pkg::RFS_ACKTL_OFF: nxt_dat[7:0] = ackd_ff[7:0];
            rfs_pkg::RFS_ACKTH_OFF: nxt_dat[7:0] = ackd_ff[15:8];
            rfs_pkg::RFS_RXBASE_OFF: nxt_dat[7:0] = rxbase_ff;
            rfs_pkg::RFS_TXBASE_OFF: nxt_dat[7:0] = txbase_ff;
            default: nxt_dat = 32'h0000_0000;
        endcase
        nxt_ack = acc && hit;
        nxt_err = acc && !hit;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_dat_o <= nxt_dat;
            wb_ack_o <= nxt_ack;
            wb_err_o <= nxt_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Radio controls
    assign radio_o.agc_freeze = agc_ff;
    assign radio_o.synth_on = (state_ff != rfs_pkg::RFS_S_OFF) || tuning_ff;
    assign radio_o.pa_on = (state_ff == rfs_pkg::RFS_S_TX);
    assign radio_o.bb_active = ctrl_ff[rfs_pkg::RFS_CTRL_BBEN] || (state_ff == rfs_pkg::RFS_S_TX);
    assign radio_o.tx_is_ack = tx_ack_ff;
    // RL17: length includes checksum octets
    assign tx_len_o = txfl_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_rx_cmd;
        @(posedge ref_clk) disable iff (!reset_n)
        (wr_at(rfs_pkg::RFS_CMD_OFF) && cmd == rfs_pkg::RFS_CMD_RX && state_ff == rfs_pkg::RFS_S_PREP
         && !(ack_pend_ff && ackt_ff == 16'h0000)) |=> state_ff == rfs_pkg::RFS_S_RX;
    endproperty
    a_rx_cmd: assert property (p_rx_cmd) else $error("rx command ignored"); // RL1

    property p_agc;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_RX && ctrl_ff[3] && rx_ev.preamble && !rx_ev.frame_end
         && !wr_at(rfs_pkg::RFS_CMD_OFF)) |=> agc_ff;
    endproperty
    a_agc: assert property (p_agc) else $error("gain not frozen"); // RL2

    property p_rxfe;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_RX && ctrl_ff[3] && rx_ev.frame_end && rx_ev.fcs_ok
         && !wr_at(rfs_pkg::RFS_CMD_OFF)) |=> (irq_ff[2] && state_ff == rfs_pkg::RFS_S_PREP);
    endproperty
    a_rxfe: assert property (p_rxfe) else $error("frame end not handled"); // RL5

    property p_bad;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_RX && rx_ev.frame_end && !rx_ev.fcs_ok && !ed_done
         && !wr_at(rfs_pkg::RFS_CMD_OFF)) |=> (state_ff == rfs_pkg::RFS_S_RX && !$past(ed_done));
    endproperty
    a_bad: assert property (p_bad) else $error("bad frame left receive"); // RL6

    property p_off_tx;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_OFF) |=> state_ff != rfs_pkg::RFS_S_TX;
    endproperty
    a_off_tx: assert property (p_off_tx) else $error("transmit from off"); // RL23

    property p_rdy;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_OFF && tuning_ff && cnt_ff == 16'h0000
         && !wr_at(rfs_pkg::RFS_CMD_OFF)) |=> (state_ff == rfs_pkg::RFS_S_PREP && irq_ff[5]);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready missing"); // RL9

    property p_busy;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_RX && ed_done && !ed_auto_ff && !wr_at(rfs_pkg::RFS_CMD_OFF))
        |=> ctrl_ff[5] == ($past(energy_s2_ff) > $past(edt_ff));
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit stale"); // RL13

    property p_txfe;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_ff == rfs_pkg::RFS_S_TX && cnt_ff == 16'h0000) |=> (irq_ff[3] && state_ff == rfs_pkg::RFS_S_PREP);
    endproperty
    a_txfe: assert property (p_txfe) else $error("tx end missing"); // RL16

endmodule : rfs_seq

// ===== tb.sv
/* Self-checking bench of rfs_seq: register table, state moves, frames, energy.
   Assumes the register map and timing given in rfs_pkg. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ack, err, e_seen;
    logic [7:0] adr = 8'h00, energy = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [10:0] tx_len;
    rfs_pkg::rfs_rx_ev_t rx_ev;
    rfs_pkg::rfs_radio_t radio;
    int error_cnt = 0, samples_checked = 0;
    logic [31:0] rows [0:3][0:2] = '{'{32'h24, 32'h0C, 32'h0C}, '{32'h28, 32'h00, 32'h00},
        '{32'h18, 32'hAC, 32'hAC}, '{32'h2C, 32'h04, 32'h04}};
    rfs_seq #(.ED_CYC(8)) rfs_seq_inst (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .rx_ev(rx_ev), .energy_in(energy),
        .tx_done(1'b0), .radio_o(radio), .tx_len_o(tx_len));
    rfs_demod_model rfs_demod_model_inst (.ref_clk(ref_clk), .rx_ev(rx_ev));
    initial forever #2.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
        q = rdat;
        e_seen = err;
        if (n >= 40) chk("bus answer", 1, 0);
        cyc <= 0;
        stb <= 0;
    endtask : wb
    // Polls a register until masked value matches, then compares it
    task wait_rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int i;
        i = 0;
        do begin
            wb(0, a, 0);
            i++;
        end while (i < 300 && (q & m) !== e);
        chk(n, e, q & m);
    endtask : wait_rd
    task frame(input logic ok, input logic am);
        rfs_demod_model_inst.pulse('{preamble: 1'b1, default: 1'b0});
        @(posedge ref_clk);
        chk("agc_freeze", 1, radio.agc_freeze);
        rfs_demod_model_inst.pulse('{header_ok: 1'b1, default: 1'b0});
        rfs_demod_model_inst.pulse('{addr_match: am, default: 1'b0});
        rfs_demod_model_inst.pulse('{frame_end: 1'b1, fcs_ok: ok, addr_match: am, length: 11'h123, default: 1'b0});
        @(posedge ref_clk);
    endtask : frame
    task summarize;
        $display("compared %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        q = 32'hFFFF_FFFF;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1;
        wait_rd("reset state", 8'h04, 32'hF, 32'h1);
        wait_rd("reset ctrl", 8'h0C, 32'hFF, 32'h08);
        for (int r = 0; r < 4; r++) begin
            wb(1, rows[r][0][7:0], rows[r][1]);
            wait_rd("reg readback", rows[r][0][7:0], 32'hFF, rows[r][2]);
        end
        chk("tx_len_o", 32'h0C, {21'h0, tx_len});
        wb(0, 8'hFC, 0);
        chk("unmapped err", 1, e_seen);
        $display("registers done");
        wb(1, 8'h00, 3);
        wait_rd("tx from off", 8'h04, 32'hF, 32'h1);
        wb(1, 8'h00, 1);
        wait_rd("prep ready irq", 8'h08, 32'h20, 32'h20);
        wait_rd("prep state", 8'h04, 32'hF, 32'h2);
        wb(1, 8'h08, 32'h3F);
        wb(1, 8'h00, 2);
        wait_rd("rx state", 8'h04, 32'hF, 32'h4);
        frame(0, 0);
        chk("agc released", 0, radio.agc_freeze);
        wait_rd("bad frame irq", 8'h08, 32'h7, 32'h1);
        wait_rd("stay rx", 8'h04, 32'hF, 32'h4);
        wb(1, 8'h08, 32'h3F);
        wb(1, 8'h0C, 32'h1A);
        frame(1, 1);
        wait_rd("good frame irq", 8'h08, 32'h7, 32'h7);
        wait_rd("to prep", 8'h04, 32'hF, 32'h2);
        wait_rd("rx len low", 8'h1C, 32'hFF, 32'h23);
        wait_rd("rx len high", 8'h20, 32'h7, 32'h1);
        wait_rd("ack tx end", 8'h08, 32'h8, 32'h8);
        wait_rd("after ack", 8'h04, 32'hF, 32'h2);
        $display("frames done");
        for (int b = 0; b < 2; b++) begin
            wb(1, 8'h08, 32'h3F);
            wb(1, 8'h0C, 32'h01);
            energy <= b ? 8'hF0 : 8'h10;
            wb(1, 8'h00, 2);
            wait_rd("rx for cca", 8'h04, 32'hF, 32'h4);
            wb(1, 8'h10, 1);
            wait_rd("energy done", 8'h08, 32'h10, 32'h10);
            wait_rd("auto end irq", 8'h08, 32'h28, b ? 32'h08 : 32'h28);
            wait_rd("busy bit", 8'h0C, 32'h20, b ? 32'h20 : 32'h0);
            wait_rd("cca state", 8'h04, 32'hF, b ? 32'h4 : 32'h2);
        end
        wb(1, 8'h0C, 32'h09);
        chk("bb_active", 1, radio.bb_active);
        $display("energy done");
        reset_n <= 0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1;
        wait_rd("reset again state", 8'h04, 32'hF, 32'h1);
        wait_rd("reset again ctrl", 8'h0C, 32'hFF, 32'h08);
        $display("reset done");
        summarize();
    end
endmodule : tb
